/* inc/adcrw_regs.vh */
// register indexes, fields, reset values and modes of the result and window register bank
`ifndef ADCRW_REGS_VH
`define ADCRW_REGS_VH

// register indexes; byte address on the bus is four times the index
`define ADCRW_IDX_WINMODE 6'h04
`define ADCRW_IDX_FLAGS 6'h0B
`define ADCRW_IDX_HALTCTRL 6'h0C
`define ADCRW_IDX_BUFFER 6'h0D
`define ADCRW_IDX_CONV_LO 6'h10
`define ADCRW_IDX_CONV_HI 6'h11
`define ADCRW_IDX_WLOW_LO 6'h12
`define ADCRW_IDX_WLOW_HI 6'h13
`define ADCRW_IDX_WHIGH_LO 6'h14
`define ADCRW_IDX_WHIGH_HI 6'h15

// field positions
`define ADCRW_HALTCTRL_RUN_BIT 0
`define ADCRW_FLAGS_DONE_BIT 0
`define ADCRW_FLAGS_MATCH_BIT 1
`define ADCRW_WINMODE_MODE_LSB 0
`define ADCRW_WINMODE_MODE_MSB 2
`define ADCRW_WINMODE_ACC_LSB 4
`define ADCRW_WINMODE_ACC_MSB 6

// reset values
`define ADCRW_RST_BYTE 8'h00
`define ADCRW_RST_WORD 16'h0000

// converter codes
`define ADCRW_CODE_MAX 10'h3FF
`define ADCRW_CODE_MIN 10'h000

// accumulation limit: 2**6 = 64 samples
`define ADCRW_ACC_LOG2_MAX 3'h6

// window comparator modes
`define ADCRW_WMODE_NONE 3'h0
`define ADCRW_WMODE_BELOW 3'h1
`define ADCRW_WMODE_ABOVE 3'h2
`define ADCRW_WMODE_BETWEEN 3'h3
`define ADCRW_WMODE_APART 3'h4

`endif

/* src/adcrw_core.v */
// result, window threshold, byte buffer and halt control registers of the converter, on APB
//
// Contract
// - run bit clear: halt and ignore events
// - run bit set: keep running when halted
// - one shared byte buffer at 0x0D
// - low byte at base, high at base+1
// - input above reference reads 0x3FF
// - input below zero reads 0x000
// - at most 64 samples accumulated
// - unsigned straight binary results
// - 10-bit raw code in low bits
// - read-only result at 0x10, reset zero
// - window compares final accumulated value
// - lower limit register at 0x12
// - upper limit register at 0x14
// - between and apart window modes
// - compare once per measurement, set flag
// - result read or one clears flags
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "adcrw_regs.vh"

module adcrw_core #(
    parameter CODE_W = 10,
    parameter SUM_W = 16
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire debug_halted,
    input wire start_event,
    input wire sample_valid,
    input wire [CODE_W-1:0] sample_code,
    input wire sample_over,
    input wire sample_under,
    output wire conv_run,
    output wire conv_start,
    output wire sample_done_flag,
    output wire window_match_flag
);

////////////////////////////////////////////////////////////////////////////////
// registers

reg [7:0] halt_behaviour_ctrl_r;
reg [7:0] byte_access_buffer_r;
reg [SUM_W-1:0] conversion_output_r;
wire [SUM_W-1:0] lower_window_limit_r;
wire [SUM_W-1:0] upper_window_limit_r;
reg [7:0] winmode_r;
wire done_r;
wire match_r;
reg [SUM_W-1:0] acc_r;
reg [6:0] cnt_r;
// high byte of a result read, taken with its low byte
reg [7:0] hi_snap_r;
// result replaced at the setup edge of a read
reg out_moved_r;

wire run_while_halted;
wire active;
wire [2:0] wmode;
wire [2:0] acc_log2;
wire [6:0] acc_target;

assign run_while_halted = halt_behaviour_ctrl_r[`ADCRW_HALTCTRL_RUN_BIT];
assign active = ~debug_halted | run_while_halted;
assign conv_run = active;
assign conv_start = start_event & active;
assign sample_done_flag = done_r;
assign window_match_flag = match_r;

assign wmode = winmode_r[`ADCRW_WINMODE_MODE_MSB:`ADCRW_WINMODE_MODE_LSB];
assign acc_log2 = (winmode_r[`ADCRW_WINMODE_ACC_MSB:`ADCRW_WINMODE_ACC_LSB] >
                   `ADCRW_ACC_LOG2_MAX) ? `ADCRW_ACC_LOG2_MAX :
                  winmode_r[`ADCRW_WINMODE_ACC_MSB:`ADCRW_WINMODE_ACC_LSB];
assign acc_target = 7'h01 << acc_log2;

////////////////////////////////////////////////////////////////////////////////
// sample path

reg [CODE_W-1:0] code_sat;
reg [SUM_W-1:0] acc_sum;
reg meas_end;
reg win_hit;
wire sample_take;

assign sample_take = sample_valid & active;

always @* begin
    if (sample_over) begin
        code_sat = `ADCRW_CODE_MAX;
    end else if (sample_under) begin
        code_sat = `ADCRW_CODE_MIN;
    end else begin
        code_sat = sample_code;
    end
    acc_sum = acc_r + {{(SUM_W-CODE_W){1'b0}}, code_sat};
    // a target lowered mid-sum still ends it; no wrap past 64
    meas_end = sample_take & ((cnt_r + 7'h01) >= acc_target);
    case (wmode)
        `ADCRW_WMODE_BELOW: win_hit = acc_sum < lower_window_limit_r;
        `ADCRW_WMODE_ABOVE: win_hit = acc_sum > upper_window_limit_r;
        `ADCRW_WMODE_BETWEEN: win_hit = (acc_sum > lower_window_limit_r) &&
                                        (acc_sum < upper_window_limit_r);
        `ADCRW_WMODE_APART: win_hit = (acc_sum < lower_window_limit_r) ||
                                      (acc_sum > upper_window_limit_r);
        default: win_hit = 1'b0;
    endcase
end

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        acc_r <= `ADCRW_RST_WORD;
        cnt_r <= 7'h00;
        conversion_output_r <= `ADCRW_RST_WORD;
    end else if (sample_take) begin
        if (meas_end) begin
            acc_r <= `ADCRW_RST_WORD;
            cnt_r <= 7'h00;
            conversion_output_r <= acc_sum;
        end else begin
            acc_r <= acc_sum;
            cnt_r <= cnt_r + 7'h01;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// apb decode

wire [5:0] idx;
wire setup_ph;
wire wr_go;
wire rd_go;
reg mapped;
reg [7:0] rd_byte;

assign idx = paddr[7:2];
assign setup_ph = psel & ~penable;
// side effects only at the completing edge
assign wr_go = psel & penable & pready & pwrite & ~pslverr & pstrb[0];
assign rd_go = psel & penable & pready & ~pwrite & ~pslverr;

always @* begin
    mapped = 1'b1;
    rd_byte = 8'h00;
    case (idx)
        `ADCRW_IDX_WINMODE: rd_byte = winmode_r;
        `ADCRW_IDX_FLAGS: rd_byte = {6'h00, match_r, done_r};
        `ADCRW_IDX_HALTCTRL: rd_byte = halt_behaviour_ctrl_r;
        `ADCRW_IDX_BUFFER: rd_byte = byte_access_buffer_r;
        `ADCRW_IDX_CONV_LO: rd_byte = conversion_output_r[7:0];
        `ADCRW_IDX_CONV_HI: rd_byte = byte_access_buffer_r;
        `ADCRW_IDX_WLOW_LO: rd_byte = lower_window_limit_r[7:0];
        `ADCRW_IDX_WLOW_HI: rd_byte = byte_access_buffer_r;
        `ADCRW_IDX_WHIGH_LO: rd_byte = upper_window_limit_r[7:0];
        `ADCRW_IDX_WHIGH_HI: rd_byte = byte_access_buffer_r;
        default: mapped = 1'b0;
    endcase
    if (|paddr[31:8]) begin
        mapped = 1'b0;
    end
end

// one wait-free access phase; data held in flops
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        prdata <= 32'h00000000;
        pready <= 1'b0;
        pslverr <= 1'b0;
        hi_snap_r <= 8'h00;
        out_moved_r <= 1'b0;
    end else begin
        pready <= setup_ph;
        pslverr <= setup_ph & ~mapped;
        out_moved_r <= meas_end;
        if (setup_ph) begin
            hi_snap_r <= conversion_output_r[15:8];
        end
        if (setup_ph & ~pwrite & mapped) begin
            prdata <= {24'h000000, rd_byte};
        end else if (setup_ph) begin
            prdata <= 32'h00000000;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// register writes

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        halt_behaviour_ctrl_r <= `ADCRW_RST_BYTE;
        winmode_r <= `ADCRW_RST_BYTE;
        byte_access_buffer_r <= `ADCRW_RST_BYTE;
    end else if (wr_go) begin
        case (idx)
            `ADCRW_IDX_WINMODE: winmode_r <= {1'b0, pwdata[6:4], 1'b0, pwdata[2:0]};
            `ADCRW_IDX_HALTCTRL: halt_behaviour_ctrl_r <= {7'h00, pwdata[0]};
            `ADCRW_IDX_BUFFER: byte_access_buffer_r <= pwdata[7:0];
            `ADCRW_IDX_WLOW_LO: byte_access_buffer_r <= pwdata[7:0];
            `ADCRW_IDX_WHIGH_LO: byte_access_buffer_r <= pwdata[7:0];
            default: ;
        endcase
    end else if (rd_go) begin
        case (idx)
            // snapshot keeps both bytes from one result
            `ADCRW_IDX_CONV_LO: byte_access_buffer_r <= hi_snap_r;
            `ADCRW_IDX_WLOW_LO: byte_access_buffer_r <= lower_window_limit_r[15:8];
            `ADCRW_IDX_WHIGH_LO: byte_access_buffer_r <= upper_window_limit_r[15:8];
            default: ;
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////////
// limit commits; the high-byte write lands both halves at once

wire wlow_commit;
wire whigh_commit;

assign wlow_commit = wr_go & (idx == `ADCRW_IDX_WLOW_HI);
assign whigh_commit = wr_go & (idx == `ADCRW_IDX_WHIGH_HI);

adcrw_word u_lower_limit (
    .pclk(pclk),
    .presetn(presetn),
    .commit(wlow_commit),
    .hi_byte(pwdata[7:0]),
    .lo_byte(byte_access_buffer_r),
    .word_r(lower_window_limit_r)
);

adcrw_word u_upper_limit (
    .pclk(pclk),
    .presetn(presetn),
    .commit(whigh_commit),
    .hi_byte(pwdata[7:0]),
    .lo_byte(byte_access_buffer_r),
    .word_r(upper_window_limit_r)
);

////////////////////////////////////////////////////////////////////////////////
// flags; a new measurement beats a clear in the same cycle

wire clr_by_read;
wire clr_done_w;
wire clr_match_w;

// result read clears
// a read that raced a new result leaves its flags set
assign clr_by_read = rd_go & (idx == `ADCRW_IDX_CONV_LO) & ~out_moved_r;
assign clr_done_w = wr_go & (idx == `ADCRW_IDX_FLAGS) & pwdata[`ADCRW_FLAGS_DONE_BIT];
assign clr_match_w = wr_go & (idx == `ADCRW_IDX_FLAGS) & pwdata[`ADCRW_FLAGS_MATCH_BIT];

adcrw_flag u_done_flag (
    .pclk(pclk),
    .presetn(presetn),
    .set_in(meas_end),
    .clr_in(clr_by_read | clr_done_w),
    .flag_r(done_r)
);

adcrw_flag u_match_flag (
    .pclk(pclk),
    .presetn(presetn),
    .set_in(meas_end & win_hit),
    .clr_in(clr_by_read | clr_match_w),
    .flag_r(match_r)
);

endmodule // adcrw_core

////////////////////////////////////////////////////////////////////////////////
// sticky status bit; set wins over clear

module adcrw_flag (
    input wire pclk,
    input wire presetn,
    input wire set_in,
    input wire clr_in,
    output reg flag_r
);

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        flag_r <= 1'b0;
    // a clear in the same cycle must not lose a fresh event
    end else if (set_in) begin
        flag_r <= 1'b1;
    end else if (clr_in) begin
        flag_r <= 1'b0;
    end
end

endmodule // adcrw_flag

////////////////////////////////////////////////////////////////////////////////
// 16-bit threshold loaded whole from buffer and high byte

module adcrw_word (
    input wire pclk,
    input wire presetn,
    input wire commit,
    input wire [7:0] hi_byte,
    input wire [7:0] lo_byte,
    output reg [15:0] word_r
);

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        word_r <= `ADCRW_RST_WORD;
    end else if (commit) begin
        word_r <= {hi_byte, lo_byte};
    end
end

endmodule // adcrw_word
`default_nettype wire

/* verification/adcrw_sva.sv */
// assertion checker for the result and window register bank
`timescale 1ns/1ps
`default_nettype none
module adcrw_sva (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic debug_halted,
    input wire logic start_event,
    input wire logic sample_valid,
    input wire logic conv_run,
    input wire logic conv_start,
    input wire logic sample_done_flag,
    input wire logic window_match_flag
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("ready too long");
    a_err_read_zero: assert property (pslverr && !pwrite |-> prdata == 32'h00000000)
        else $error("refused read data");
    a_start_gate: assert property (conv_start == (start_event && conv_run))
        else $error("start not gated");
    a_free_run: assert property (!debug_halted |-> conv_run)
        else $error("stopped while running");
    a_halt_ignore: assert property (!conv_run |=> !$rose(sample_done_flag))
        else $error("sample taken while halted");
    a_done_cause: assert property ($rose(sample_done_flag) |-> $past(sample_valid))
        else $error("done without sample");
    a_match_cause: assert property ($rose(window_match_flag) |-> $past(sample_valid))
        else $error("match without sample");
    c_start: cover property (conv_start);
    c_refused: cover property (pslverr);
    c_match: cover property ($rose(window_match_flag));
endmodule // adcrw_sva
////////////////////////////////////////////////////////////////////////////////
bind adcrw_core adcrw_sva u_sva (.pclk, .presetn, .psel, .penable, .pwrite, .prdata, .pready,
    .pslverr, .debug_halted, .start_event, .sample_valid, .conv_run, .conv_start,
    .sample_done_flag, .window_match_flag);
`default_nettype wire

/* verification/adcrw_host.sv */
// bus master model of the cpu side
`timescale 1ns/1ps
`default_nettype none
module adcrw_host (
    input wire logic pclk,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    output var logic psel,
    output var logic penable,
    output var logic pwrite,
    output var logic [31:0] paddr,
    output var logic [31:0] pwdata,
    output var logic [3:0] pstrb
);
    initial {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    // bounded wait: a dead slave must not hang the run
    task automatic xfer(input logic w, input logic [5:0] idx, input logic [7:0] d,
        output logic [7:0] q, output logic e, output logic to);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {24'h000000, idx, 2'h0};
        pwdata <= {24'h000000, d};
        pstrb <= 4'hF;
        @(posedge pclk);
        penable <= 1'b1;
        to = 1'b1;
        for (int i = 0; i < 8 && to; i++) begin
            @(posedge pclk);
            to = pready !== 1'b1;
        end
        q = prdata[7:0];
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule // adcrw_host
`default_nettype wire

/* verification/tb.sv */
// self-checking bench for the result and window register bank
`timescale 1ns/1ps
`default_nettype none
`include "adcrw_regs.vh"
module tb;
    logic pclk, presetn, debug_halted, start_event, sample_valid, sample_over, sample_under;
    logic psel, penable, pwrite, pready, pslverr, conv_run, conv_start;
    logic sample_done_flag, window_match_flag, e, to;
    logic [9:0] sample_code;
    logic [31:0] paddr, pwdata, prdata;
    logic [3:0] pstrb;
    logic [7:0] q;
    logic [15:0] s, lo_lim, hi_lim;
    logic [5:0] rst_ids [8] = '{6'h0C, 6'h0D, 6'h10, 6'h11, 6'h12, 6'h13, 6'h14, 6'h15};
    int error_cnt, check_count;
    adcrw_core uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .prdata, .pready, .pslverr, .debug_halted, .start_event, .sample_valid, .sample_code,
        .sample_over, .sample_under, .conv_run, .conv_start, .sample_done_flag,
        .window_match_flag);
    adcrw_host host (.pclk, .pready, .prdata, .pslverr, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pstrb);
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic rw(input logic w, input logic [5:0] idx, input logic [7:0] d);
        host.xfer(w, idx, d, q, e, to);
        if (to) begin
            error_cnt++;
            complete_run();
        end
    endtask
    task automatic wr16(input logic [5:0] idx, input logic [15:0] v);
        rw(1'b1, idx, v[7:0]);
        rw(1'b1, idx + 6'h01, v[15:8]);
    endtask
    task automatic chk16(input string what, input logic [5:0] idx, input logic [15:0] v);
        logic [7:0] lo_b;
        rw(1'b0, idx, 8'h00);
        lo_b = q;
        rw(1'b0, idx + 6'h01, 8'h00);
        check(what, {q, lo_b}, v);
    endtask
    function automatic logic hit(input logic [2:0] m, input logic [15:0] v);
        case (m)
            `ADCRW_WMODE_BELOW: return v < lo_lim;
            `ADCRW_WMODE_ABOVE: return v > hi_lim;
            `ADCRW_WMODE_BETWEEN: return v > lo_lim && v < hi_lim;
            `ADCRW_WMODE_APART: return v < lo_lim || v > hi_lim;
            default: return 1'b0;
        endcase
    endfunction
    task automatic meas(input logic [2:0] m, input logic [2:0] k, input logic ov, input logic wc);
        logic o, u;
        logic [9:0] c;
        rw(1'b1, `ADCRW_IDX_WINMODE, {1'b0, k, 1'b0, m});
        s = 16'h0000;
        repeat (1 << ((k > 3'h6) ? 6 : k)) begin
            o = ov | ($urandom % 4 == 0);
            u = $urandom % 4 == 1;
            c = 10'($urandom);
            @(posedge pclk);
            sample_valid <= 1'b1;
            sample_code <= c;
            sample_over <= o;
            sample_under <= u;
            s = s + (o ? 16'h03FF : u ? 16'h0000 : {6'h00, c});
        end
        @(posedge pclk);
        sample_valid <= 1'b0;
        @(posedge pclk);
        check("done", 16'(sample_done_flag), 16'h0001);
        check("match", 16'(window_match_flag), 16'(hit(m, s)));
        if (wc) rw(1'b1, `ADCRW_IDX_FLAGS, 8'h03);
        else chk16("result", `ADCRW_IDX_CONV_LO, s);
        rw(1'b0, `ADCRW_IDX_FLAGS, 8'h00);
        check("flags", 16'(q), 16'h0000);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {error_cnt, check_count} = '0;
        {presetn, debug_halted, start_event, sample_valid, sample_over, sample_under} = '0;
        sample_code = 10'h000;
        q = 8'($urandom(32'hAD2E67FA));
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rst_ids[i]) begin
            rw(1'b0, rst_ids[i], 8'h00);
            check("reset value", 16'(q), 16'h0000);
        end
        s = 16'($urandom);
        rw(1'b1, `ADCRW_IDX_BUFFER, s[7:0]);
        rw(1'b0, `ADCRW_IDX_BUFFER, 8'h00);
        check("buffer", 16'(q), 16'(s[7:0]));
        rw(1'b0, 6'h3F, 8'h00);
        check("unmapped", {7'h00, e, q}, 16'h0100);
        // second pass uses limits that split the single-sample range
        for (int i = 0; i < 2; i++) begin
            lo_lim = i ? 16'h0100 : 16'($urandom);
            hi_lim = i ? 16'h0300 : 16'($urandom);
            wr16(`ADCRW_IDX_WLOW_LO, lo_lim);
            wr16(`ADCRW_IDX_WHIGH_LO, hi_lim);
            chk16("lower limit", `ADCRW_IDX_WLOW_LO, lo_lim);
            chk16("upper limit", `ADCRW_IDX_WHIGH_LO, hi_lim);
        end
        wr16(`ADCRW_IDX_CONV_LO, 16'hA5A5);
        chk16("result ro", `ADCRW_IDX_CONV_LO, 16'h0000);
        $display("test registers done");
        for (int m = 0; m < 8; m++) repeat (3) meas(3'(m), 3'h0, 1'b0, 1'b0);
        meas(`ADCRW_WMODE_BETWEEN, 3'h3, 1'b0, 1'b0);
        meas(`ADCRW_WMODE_APART, 3'h7, 1'b1, 1'b0);
        $display("test measurements done");
        // single-sample target: a taken sample would raise the flag
        rw(1'b1, `ADCRW_IDX_WINMODE, 8'h00);
        @(posedge pclk);
        debug_halted <= 1'b1;
        start_event <= 1'b1;
        sample_valid <= 1'b1;
        @(posedge pclk);
        sample_valid <= 1'b0;
        @(posedge pclk);
        check("halted", {conv_run, conv_start, sample_done_flag}, 16'h0000);
        rw(1'b1, `ADCRW_IDX_HALTCTRL, 8'h01);
        @(posedge pclk);
        check("run bit", {conv_run, conv_start}, 16'h0003);
        meas(`ADCRW_WMODE_NONE, 3'h0, 1'b0, 1'b1);
        start_event <= 1'b0;
        $display("test debug halt done");
        complete_run();
    end
endmodule // tb
`default_nettype wire
